// File: csi_cfg.svh
`ifndef CSI_CFG_SVH
`define CSI_CFG_SVH
// register addresses (4-bit data bus, 16-bit address)
`define CSI_ADDR_PULLUP   16'hff45
`define CSI_ADDR_CTRL     16'hff70
`define CSI_ADDR_MODE     16'hff71
`define CSI_ADDR_DATA_LO  16'hff72
`define CSI_ADDR_DATA_HI  16'hff73
`define CSI_ADDR_IRQ_EN   16'hffe3
`define CSI_ADDR_IRQ_FLAG 16'hfff3
// field positions
`define CSI_BIT_SIN_PU    0
`define CSI_BIT_SCK_PU    2
`define CSI_BIT_ENABLE    0
`define CSI_BIT_TRIGGER   1
`define CSI_BIT_PHASE     2
`define CSI_BIT_ORDER     3
`define CSI_BIT_IRQ       0
// reset values
`define CSI_RST_PULLUP    1'b1
`define CSI_RST_ZERO      1'b0
`define CSI_RST_MODE      2'h0
// bit count of one transfer
`define CSI_BITS_LAST     3'h7
`define CSI_BITS_ZERO     3'h0
`endif

// File: csi_pkg.sv
package csi_pkg;
  // clock source encodings
  typedef enum logic [1:0] {
    CSI_SRC_EXT   = 2'b00,
    CSI_SRC_TIMER = 2'b01,
    CSI_SRC_HALF  = 2'b10,
    CSI_SRC_OSC   = 2'b11
  } csi_src_t;
  // transfer state
  typedef enum logic [0:0] {
    CSI_IDLE = 1'b0,
    CSI_RUN  = 1'b1
  } csi_state_t;
endpackage

// File: csi_top.sv
`timescale 1ns/1ps
`include "csi_cfg.svh"
module csi_top
  import csi_pkg::*;
#(
  parameter bit NEG_POLARITY = 1'b1            // mask-option clock polarity
)(
  input  wire logic        clk_i,              // system clock, 20 MHz
  input  wire logic        reset_n_i,          // synchronous reset, active low
  input  wire logic [15:0] addr_i,             // register address
  input  wire logic [3:0]  wdata_i,            // write data
  input  wire logic        wr_i,               // write strobe
  input  wire logic        rd_i,               // read strobe
  output logic      [3:0]  rdata_o,            // read data, one cycle later
  input  wire logic        slow_osc_tick_i,    // slow oscillator edge enable
  input  wire logic        timer1_underflow_i, // timer 1 underflow pulse
  input  wire logic        sclk_in_i,          // shift clock pin level
  output logic             sclk_out_o,         // shift clock drive value
  output logic             sclk_oe_o,          // shift clock drive enable
  output logic             sclk_pullup_o,      // shift clock pull-up on
  input  wire logic        serial_in_pin_i,    // serial input pin
  output logic             serial_in_pullup_o, // serial input pull-up on
  output logic             serial_out_pin_o,   // serial output value
  output logic             serial_out_oe_o,    // serial output enable
  output logic             ready_out_n_o,      // ready, active low
  output logic             ready_oe_o,         // ready pin owned by serial
  output logic             serial_fn_o,        // port pins in serial function
  output logic             irq_o               // interrupt request level
);

  // software-visible control
  logic       serial_input_pullup_reg;   // input pull-up
  logic       shift_clock_pullup_reg;    // clock pull-up, storage in master
  logic       serial_function_enable_reg; // port function select
  logic [1:0] clock_source_select_reg;   // clock mode
  logic       sample_phase_select_reg;   // sampling edge
  logic       bit_order_select_reg;      // msb first when one
  logic [7:0] shift_data_reg;            // shift register and data
  logic       serial_irq_enable_reg;     // interrupt mask
  logic       serial_irq_flag_reg;       // interrupt factor
  csi_state_t state_reg;                 // idle or running
  logic [2:0] bit_cnt_reg;               // completed bits
  logic       ready_n_reg;               // ready output state
  logic       half_div_reg;              // divide-by-two for osc or timer
  logic       int_sclk_reg;              // internal clock level
  logic       sclk_prev_reg;             // previous shift clock level, internal or external
  logic       sin_latch_reg;             // bit sampled on the sampling edge
  logic [3:0] rdata_reg;                 // registered read data

  // decoded strobes
  logic wr_pullup, wr_ctrl, wr_mode, wr_lo, wr_hi, wr_en, wr_flag;
  logic master, trigger, clk_tick, rise, fall, act_edge, smp_edge, done;
  logic sclk_now;

  // address compare, reused for each register
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  assign wr_pullup = wr_i && hit(addr_i, `CSI_ADDR_PULLUP);
  assign wr_ctrl   = wr_i && hit(addr_i, `CSI_ADDR_CTRL);
  assign wr_mode   = wr_i && hit(addr_i, `CSI_ADDR_MODE);
  assign wr_lo     = wr_i && hit(addr_i, `CSI_ADDR_DATA_LO);
  assign wr_hi     = wr_i && hit(addr_i, `CSI_ADDR_DATA_HI);
  assign wr_en     = wr_i && hit(addr_i, `CSI_ADDR_IRQ_EN);
  assign wr_flag   = wr_i && hit(addr_i, `CSI_ADDR_IRQ_FLAG);

  assign master  = (clock_source_select_reg != CSI_SRC_EXT);
  // a second trigger while running is ignored here; software must not rely on it
  assign trigger = wr_ctrl && wdata_i[`CSI_BIT_TRIGGER] && (state_reg == CSI_IDLE);

  // internal clock tick: full osc, osc/2 or timer underflow/2
  always_comb
  begin
    case (csi_src_t'(clock_source_select_reg))
      CSI_SRC_OSC:   clk_tick = slow_osc_tick_i;
      CSI_SRC_HALF:  clk_tick = slow_osc_tick_i && half_div_reg;
      CSI_SRC_TIMER: clk_tick = timer1_underflow_i && half_div_reg;
      default:       clk_tick = 1'b0;
    endcase
  end

  // divide-by-two for the half-rate sources
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      half_div_reg <= `CSI_RST_ZERO;
    else if (clock_source_select_reg == CSI_SRC_HALF && slow_osc_tick_i)
      half_div_reg <= ~half_div_reg;
    else if (clock_source_select_reg == CSI_SRC_TIMER && timer1_underflow_i)
      half_div_reg <= ~half_div_reg;
  end

  // internal clock generator: each tick is one half period, idle level inactive
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      int_sclk_reg <= NEG_POLARITY;
    else if (state_reg == CSI_IDLE)
      int_sclk_reg <= NEG_POLARITY;                                     // park idle
    else if (master && clk_tick)
      int_sclk_reg <= ~int_sclk_reg;
  end

  // edge view of the active shift clock, internal or external
  assign sclk_now = master ? int_sclk_reg : sclk_in_i;
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      sclk_prev_reg <= NEG_POLARITY;
    else
      sclk_prev_reg <= sclk_now;
  end
  assign rise     = (state_reg == CSI_RUN) && sclk_now && !sclk_prev_reg;
  assign fall     = (state_reg == CSI_RUN) && !sclk_now && sclk_prev_reg;
  assign act_edge = NEG_POLARITY ? fall : rise;
  // sampling edge: phase one is the active edge itself under negative polarity
  assign smp_edge = (sample_phase_select_reg ^ NEG_POLARITY) ? rise : fall;
  assign done     = act_edge && (bit_cnt_reg == `CSI_BITS_LAST);

  // run state and bit counter; a bit completes on each output edge
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_reg   <= CSI_IDLE;
      bit_cnt_reg <= `CSI_BITS_ZERO;
    end
    else if (trigger)
    begin
      state_reg   <= CSI_RUN;
      bit_cnt_reg <= `CSI_BITS_ZERO;
    end
    else if (done)
    begin
      state_reg   <= CSI_IDLE;
      bit_cnt_reg <= `CSI_BITS_ZERO;
    end
    else if (act_edge)
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
  end

  // sample the input pin on the chosen edge
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      sin_latch_reg <= `CSI_RST_ZERO;
    else if (smp_edge)
      sin_latch_reg <= serial_in_pin_i;
  end

  // bit entering the shift register: when sampling and output share one edge
  // the pin is taken directly, otherwise the earlier sampled bit is used
  logic shift_in;                        // bit shifted in on the output edge
  assign shift_in = smp_edge ? serial_in_pin_i : sin_latch_reg;

  // shift register: loaded by software, shifted on the output edge;
  // sampled bit enters the vacated end so data reads back in order;
  // cleared at reset only so idle checks never see unknown contents
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      shift_data_reg <= {8{`CSI_RST_ZERO}};
    else if (wr_lo)
      shift_data_reg[3:0] <= wdata_i;
    else if (wr_hi)
      shift_data_reg[7:4] <= wdata_i;
    else if (act_edge)
    begin
      if (bit_order_select_reg)
        shift_data_reg <= {shift_data_reg[6:0], shift_in};
      else
        shift_data_reg <= {shift_in, shift_data_reg[7:1]};
    end
  end
  // first bit is presented from the data write; output then moves only on the active edge
  assign serial_out_pin_o = bit_order_select_reg ? shift_data_reg[7] : shift_data_reg[0];
  assign serial_out_oe_o  = serial_function_enable_reg;

  // ready output for slave mode
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      ready_n_reg <= 1'b1;
    else if (trigger && !master)
      ready_n_reg <= 1'b0;
    else if (rise || fall || state_reg == CSI_IDLE)
      ready_n_reg <= 1'b1;
  end
  assign ready_out_n_o = ready_n_reg;
  assign ready_oe_o    = serial_function_enable_reg && !master;

  // pin functions and pull-ups
  assign serial_fn_o        = serial_function_enable_reg;
  assign sclk_out_o         = int_sclk_reg;
  assign sclk_oe_o          = serial_function_enable_reg && master;
  assign serial_in_pullup_o = serial_input_pullup_reg;
  assign sclk_pullup_o      = shift_clock_pullup_reg && !master;

  // configuration registers
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      serial_input_pullup_reg    <= `CSI_RST_PULLUP;
      shift_clock_pullup_reg     <= `CSI_RST_PULLUP;
      serial_function_enable_reg <= `CSI_RST_ZERO;
      clock_source_select_reg    <= `CSI_RST_MODE;
      sample_phase_select_reg    <= `CSI_RST_ZERO;
      bit_order_select_reg       <= `CSI_RST_ZERO;
      serial_irq_enable_reg      <= `CSI_RST_ZERO;
    end
    else
    begin
      if (wr_pullup)
      begin
        serial_input_pullup_reg <= wdata_i[`CSI_BIT_SIN_PU];
        shift_clock_pullup_reg  <= wdata_i[`CSI_BIT_SCK_PU];
      end
      if (wr_ctrl)
        serial_function_enable_reg <= wdata_i[`CSI_BIT_ENABLE];
      if (wr_mode)
      begin
        clock_source_select_reg <= wdata_i[1:0];
        sample_phase_select_reg <= wdata_i[`CSI_BIT_PHASE];
        bit_order_select_reg    <= wdata_i[`CSI_BIT_ORDER];
      end
      if (wr_en)
        serial_irq_enable_reg <= wdata_i[`CSI_BIT_IRQ];
    end
  end

  // interrupt flag: completion wins over a same-cycle clear
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      serial_irq_flag_reg <= `CSI_RST_ZERO;
    else if (done)
      serial_irq_flag_reg <= 1'b1;
    else if (wr_flag && wdata_i[`CSI_BIT_IRQ])
      serial_irq_flag_reg <= 1'b0;
  end
  assign irq_o = serial_irq_flag_reg && serial_irq_enable_reg;

  // read mux, answer in the following cycle; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      rdata_reg <= 4'h0;
    else if (rd_i)
    begin
      case (addr_i)
        `CSI_ADDR_PULLUP:   rdata_reg <= {1'b0, shift_clock_pullup_reg, 1'b0,
                                          serial_input_pullup_reg};
        `CSI_ADDR_CTRL:     rdata_reg <= {2'b00, state_reg == CSI_RUN,
                                          serial_function_enable_reg};
        `CSI_ADDR_MODE:     rdata_reg <= {bit_order_select_reg, sample_phase_select_reg,
                                          clock_source_select_reg};
        `CSI_ADDR_DATA_LO:  rdata_reg <= shift_data_reg[3:0];
        `CSI_ADDR_DATA_HI:  rdata_reg <= shift_data_reg[7:4];
        `CSI_ADDR_IRQ_EN:   rdata_reg <= {3'h0, serial_irq_enable_reg};
        `CSI_ADDR_IRQ_FLAG: rdata_reg <= {3'h0, serial_irq_flag_reg};
        default:            rdata_reg <= 4'h0;
      endcase
    end
  end
  assign rdata_o = rdata_reg;

  // checks
  property p_trig_run;
    @(posedge clk_i) disable iff (!reset_n_i) trigger |=> state_reg == CSI_RUN;
  endproperty
  a_trig_run: assert property (p_trig_run) else $error("trigger did not start");
  property p_done_flag;
    @(posedge clk_i) disable iff (!reset_n_i) done |=> serial_irq_flag_reg && state_reg == CSI_IDLE;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("flag not set at end");
  property p_zero_keeps;
    @(posedge clk_i) disable iff (!reset_n_i)
      serial_irq_flag_reg && wr_flag && !wdata_i[`CSI_BIT_IRQ] |=> serial_irq_flag_reg;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost on zero write");
  property p_irq;
    @(posedge clk_i) disable iff (!reset_n_i)
      irq_o == (serial_irq_flag_reg && serial_irq_enable_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_pullup;
    @(posedge clk_i) disable iff (!reset_n_i) master |-> !sclk_pullup_o;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup in master");
  property p_ready;
    @(posedge clk_i) disable iff (!reset_n_i) trigger && !master |=> !ready_out_n_o;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not low");
  property p_rdy_oe;
    @(posedge clk_i) disable iff (!reset_n_i) master |-> !ready_oe_o;
  endproperty
  a_rdy_oe: assert property (p_rdy_oe) else $error("ready oe in master");
  property p_idle_still;
    @(posedge clk_i) disable iff (!reset_n_i)
      state_reg == CSI_IDLE && !wr_lo && !wr_hi && !wr_mode |=> $stable(shift_data_reg);
  endproperty
  a_idle_still: assert property (p_idle_still) else $error("data moved while idle");
endmodule

// File: csi_peer.sv
`timescale 1ns/1ps
// far-side serial device: slave when the device is master, clock master otherwise
module csi_peer (
  input  wire logic       clk_i,     // system clock
  input  wire logic       sclk_i,    // resolved shift clock line
  input  wire logic       serial_out_pin_i,    // serial output line
  input  wire logic       load_i,    // frame start
  input  wire logic       go_i,      // drive eight clocks
  input  wire logic       msb_i,     // bit order, one is msb first
  input  wire logic [7:0] half_i,    // half period in clocks
  input  wire logic [7:0] tx_i,      // byte sent to the device
  output logic            sclk_o,    // clock drive value
  output logic            sclk_oe_o, // clock drive enable
  output logic            sin_o,     // serial input value
  output logic            sin_oe_o,  // serial input enable
  output logic [7:0]      rx_o       // byte taken from the device
);
  int unsigned idx; // index of the bit now presented
  initial
  begin
    sclk_o = 1'b1;
    sclk_oe_o = 1'b0;
    sin_o = 1'b0;
    sin_oe_o = 1'b0;
    rx_o = 8'h00;
  end
  // first bit stands from frame start
  always @(posedge load_i)
  begin
    idx = 0;
    sin_oe_o = 1'b1;
    sin_o = msb_i ? tx_i[7] : tx_i[0];
  end
  // next bit a few clocks after the rising edge, clear of both sampling edges
  always @(posedge sclk_i)
    if (sin_oe_o)
    begin
      repeat (4) @(posedge clk_i);
      #1;
      idx++;
      if (idx < 8)
        sin_o = msb_i ? tx_i[7 - idx] : tx_i[idx];
      else
        sin_oe_o = 1'b0; // released after the frame
    end
  // take the line before the device moves it on its falling edge
  always @(negedge sclk_i)
    if (sin_oe_o)
      rx_o = msb_i ? {rx_o[6:0], serial_out_pin_i} : {serial_out_pin_i, rx_o[7:1]};
  // clock only after the trigger, never faster than twenty clocks a period
  always @(posedge go_i)
  begin
    sclk_oe_o = 1'b1;
    repeat (8)
    begin
      sclk_o = 1'b0;
      repeat (half_i) @(posedge clk_i);
      #1;
      sclk_o = 1'b1;
      repeat (half_i) @(posedge clk_i);
      #1;
    end
    sclk_oe_o = 1'b0;
  end
endmodule

// File: csi_top_tb_top.sv
`timescale 1ns/1ps
`include "csi_cfg.svh"
module csi_top_tb_top;
  logic clk, reset_n, bus_wr, bus_rd, tick, uflow, load, go, msb, mask_on;
  logic [15:0] bus_addr;
  logic [3:0]  bus_wdata, rdata;
  logic [7:0]  half, ptx, prx;
  logic sclk_out, sclk_oe, sclk_pu, sin_pu, serial_out_pin, serial_out_pin_oe, rdy_n, rdy_oe, fn, irq;
  logic p_sclk, p_sclk_oe, p_sin, p_sin_oe;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // released lines go to the pull-up or to the inverse of their last value
  wire sclk_line = sclk_oe ? sclk_out : p_sclk_oe ? p_sclk : (sclk_pu | ~p_sclk);
  wire sin_line = p_sin_oe ? p_sin : (sin_pu | ~p_sin);
  csi_top #(.NEG_POLARITY(1'b1)) uut (.clk_i(clk), .reset_n_i(reset_n), .addr_i(bus_addr),
    .wdata_i(bus_wdata), .wr_i(bus_wr), .rd_i(bus_rd), .rdata_o(rdata),
    .slow_osc_tick_i(tick), .timer1_underflow_i(uflow), .sclk_in_i(sclk_line),
    .sclk_out_o(sclk_out), .sclk_oe_o(sclk_oe), .sclk_pullup_o(sclk_pu),
    .serial_in_pin_i(sin_line), .serial_in_pullup_o(sin_pu), .serial_out_pin_o(serial_out_pin),
    .serial_out_oe_o(serial_out_pin_oe), .ready_out_n_o(rdy_n), .ready_oe_o(rdy_oe),
    .serial_fn_o(fn), .irq_o(irq));
  csi_peer peer (.clk_i(clk), .sclk_i(sclk_line), .serial_out_pin_i(serial_out_pin), .load_i(load), .go_i(go),
    .msb_i(msb), .half_i(half), .tx_i(ptx), .sclk_o(p_sclk), .sclk_oe_o(p_sclk_oe),
    .sin_o(p_sin), .sin_oe_o(p_sin_oe), .rx_o(prx));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // slow ticks every 6 clocks, timer underflows every 10
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    tick <= (cyc % 6 == 5);
    uflow <= (cyc % 10 == 9);
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic write_reg(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  // read data stand from the cycle after the strobe until the next read
  task automatic read_reg(input logic [15:0] a, output logic [3:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic check_reg(input string nm, input logic [15:0] a, input logic [3:0] exp);
    logic [3:0] d;
    read_reg(a, d);
    chk(nm, {4'h0, d}, {4'h0, exp});
  endtask
  // one whole transfer; exp_cyc is the expected length in clocks
  task automatic xfer(input logic [1:0] mode, input logic ord, input logic [7:0] tx,
                      input logic [7:0] rx, input int exp_cyc);
    logic [3:0] d;
    int t0, i;
    write_reg(`CSI_ADDR_MODE, {ord, 1'b1, mode});
    write_reg(`CSI_ADDR_DATA_LO, tx[3:0]);
    write_reg(`CSI_ADDR_DATA_HI, tx[7:4]);
    write_reg(`CSI_ADDR_CTRL, 4'h1);
    check_reg("status_idle", `CSI_ADDR_CTRL, 4'h1);
    chk("serial_fn", fn, 1);
    chk("ready_oe", rdy_oe, mode == 2'h0);
    msb <= ord;
    ptx <= rx;
    @(posedge clk);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    write_reg(`CSI_ADDR_CTRL, 4'h3);
    t0 = cyc;
    check_reg("status_run", `CSI_ADDR_CTRL, 4'h3);
    if (mode == 2'h0)
    begin
      chk("ready_low", rdy_n, 0);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
    end
    i = 0;
    do
    begin
      read_reg(`CSI_ADDR_CTRL, d);
      i++;
    end
    while (d[1] !== 1'b0 && i < 2000);
    if (i == 2000)
    begin
      n_errors++;
      summarize();
    end
    chk("length", (cyc - t0 > exp_cyc - 30) && (cyc - t0 < exp_cyc + 30), 1);
    chk("sent_byte", prx, tx);
    check_reg("recv_lo", `CSI_ADDR_DATA_LO, rx[3:0]);
    check_reg("recv_hi", `CSI_ADDR_DATA_HI, rx[7:4]);
    check_reg("flag_set", `CSI_ADDR_IRQ_FLAG, 4'h1);
    chk("irq_level", irq, mask_on);
    if (mode == 2'h0)
      chk("ready_high", rdy_n, 1);
    write_reg(`CSI_ADDR_IRQ_FLAG, 4'h0);
    check_reg("flag_kept", `CSI_ADDR_IRQ_FLAG, 4'h1);
    write_reg(`CSI_ADDR_IRQ_FLAG, 4'h1);
    check_reg("flag_clr", `CSI_ADDR_IRQ_FLAG, 4'h0);
    chk("irq_clr", irq, 0);
  endtask
  initial
  begin
    {reset_n, bus_wr, bus_rd, load, go, msb, mask_on} = 7'h00;
    {bus_addr, bus_wdata, ptx} = 28'h0;
    half = 8'h0a;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    check_reg("pullup_rst", `CSI_ADDR_PULLUP, 4'h5);
    check_reg("ctrl_rst", `CSI_ADDR_CTRL, 4'h0);
    check_reg("mode_rst", `CSI_ADDR_MODE, 4'h0);
    check_reg("mask_rst", `CSI_ADDR_IRQ_EN, 4'h0);
    check_reg("flag_rst", `CSI_ADDR_IRQ_FLAG, 4'h0);
    check_reg("unmapped", 16'hff74, 4'h0);
    chk("pullups_rst", {sin_pu, sclk_pu, fn, irq}, 8'h0c);
    write_reg(`CSI_ADDR_PULLUP, 4'h4);
    chk("sin_pu_off", {sin_pu, sclk_pu}, 8'h01);
    write_reg(`CSI_ADDR_MODE, 4'h3);
    chk("sclk_pu_master", sclk_pu, 0);
    check_reg("pullup_store", `CSI_ADDR_PULLUP, 4'h4);
    write_reg(`CSI_ADDR_PULLUP, 4'h5);
    xfer(2'h3, 1'b1, 8'ha5, 8'h3c, 90);
    write_reg(`CSI_ADDR_IRQ_EN, 4'h1);
    mask_on = 1'b1;
    xfer(2'h2, 1'b0, 8'h81, 8'hc6, 180);
    xfer(2'h1, 1'b1, 8'h5a, 8'he1, 300);
    xfer(2'h0, 1'b0, 8'h0f, 8'h96, 165);
    half = 8'h19;
    xfer(2'h0, 1'b1, 8'hf0, 8'h69, 357);
    summarize();
  end
endmodule
